// [hw/hpqc_control.sv]
// host port queue transmit and receive control with apb registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "hpqc_regs.svh"
module hpqc_control (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic txInValid,
    input wire logic [7:0] txInData,
    input wire logic txInLast,
    input wire logic [5:0] txInFrameId,
    output logic txInReady,
    output logic txOutValid,
    output logic [7:0] txOutData,
    output logic txOutLast,
    input wire logic txOutReady,
    input wire logic rxFifoAtThreshold,
    output logic txPauseRequest,
    input wire logic pauseRxValid,
    input wire logic [15:0] pauseRxQuanta,
    input wire logic rxInValid,
    input wire logic [7:0] rxInData,
    input wire logic rxInLast,
    output logic rxOutValid,
    output logic [7:0] rxOutData,
    output logic rxOutLast,
    output logic rxFrameDone,
    output logic rxFrameAccept,
    output logic rxFrameCrcError,
    output logic txRunning,
    output logic rxRunning
);
    logic [15:0] txControl;
    logic [15:0] rxControl;
    logic [31:0] stationLo;
    logic [15:0] stationHi;
    logic [31:0] hashLo;
    logic [31:0] hashHi;
    logic softReset;
    logic blockReset;
    logic [5:0] lastTxFrameId;
    logic [5:0] txFrameIdHold;

    logic accessCycle;
    logic writeNow;
    logic [5:0] regIndex;
    logic [31:0] readValue;
    logic readHit;

    hpqc_pkg::hpqc_tx_state_t txState;
    hpqc_pkg::hpqc_tx_state_t next_txState;
    logic [6:0] txCount;
    logic [6:0] txCountInc;
    logic [6:0] padTarget;
    logic [1:0] fcsIndex;
    logic [31:0] txCrc;
    logic txTake;
    logic outSlot;
    logic emitFill;
    logic txDone;
    logic next_txOutValid;
    logic [7:0] fcsByte;
    logic [15:0] pauseCount;
    logic [9:0] pausePrescale;

    logic rxInFrame;
    logic rxActive;
    logic rxFirst;
    logic rxTake;
    logic [3:0] rxCount;
    logic [3:0] rxIndex;
    logic [47:0] destAddr;
    logic [5:0] hashIdx;
    logic [5:0] hashSel;
    logic [63:0] hashTable;
    logic [31:0] rxCrc;
    logic rxEnd;
    logic rxEndLong;
    logic [31:0] rxPipe;
    logic [2:0] rxFill;
    logic [2:0] rxFillCur;
    logic [2:0] rxDrain;
    logic crcBad;
    logic isMulticast;
    logic addrOk;

    // software reset leaves the bus answering and itself alive
    assign blockReset = reset | softReset;

    // ---------------- apb slave ----------------
    assign regIndex = paddr[7:2];
    assign accessCycle = psel & penable & ~pready;
    assign writeNow = psel & penable & pready & pwrite;

    always_comb begin
        readValue = 32'h0000_0000;
        readHit = 1'b1;
        case (regIndex)
            `HPQC_IDX_TX_CONTROL: readValue = {16'h0000, txControl};
            `HPQC_IDX_TX_STATUS: readValue = {26'h000_0000, lastTxFrameId};
            `HPQC_IDX_RX_CONTROL: readValue = {16'h0000, rxControl};
            `HPQC_IDX_STATION_LO: readValue = stationLo;
            `HPQC_IDX_STATION_HI: readValue = {16'h0000, stationHi};
            `HPQC_IDX_HASH_LO: readValue = hashLo;
            `HPQC_IDX_HASH_HI: readValue = hashHi;
            `HPQC_IDX_RUN_STATUS: readValue = {29'h0000_0000,
                pauseCount != 16'h0000, rxRunning, txRunning};
            `HPQC_IDX_SOFT_RESET: readValue = {31'h0000_0000, softReset};
            default: readHit = 1'b0;
        endcase
    end

    // one wait state keeps every bus output on a flip-flop
    always_ff @(posedge clock) begin
        if (reset) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= accessCycle;
            pslverr <= accessCycle & ~readHit;
            prdata <= (accessCycle & ~pwrite) ? readValue : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            softReset <= 1'b0;
        end else if (writeNow && regIndex == `HPQC_IDX_SOFT_RESET) begin
            softReset <= pwdata[0];
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            txControl <= `HPQC_TX_CONTROL_RESET;
        end else if (writeNow && regIndex == `HPQC_IDX_TX_CONTROL) begin
            txControl <= pwdata[15:0] & `HPQC_TX_CONTROL_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            rxControl <= `HPQC_RX_CONTROL_RESET;
        end else if (writeNow && regIndex == `HPQC_IDX_RX_CONTROL) begin
            rxControl <= pwdata[15:0] & `HPQC_RX_CONTROL_MASK;
        end
    end

    // station address and hash table survive a software reset
    always_ff @(posedge clock) begin
        if (reset) begin
            stationLo <= 32'h0000_0000;
            stationHi <= 16'h0000;
            hashLo <= 32'h0000_0000;
            hashHi <= 32'h0000_0000;
        end else if (writeNow) begin
            if (regIndex == `HPQC_IDX_STATION_LO) begin
                stationLo <= pwdata;
            end
            if (regIndex == `HPQC_IDX_STATION_HI) begin
                stationHi <= pwdata[15:0];
            end
            if (regIndex == `HPQC_IDX_HASH_LO) begin
                hashLo <= pwdata;
            end
            if (regIndex == `HPQC_IDX_HASH_HI) begin
                hashHi <= pwdata;
            end
        end
    end

    // ---------------- pause handling ----------------
    always_ff @(posedge clock) begin
        if (blockReset) begin
            txPauseRequest <= 1'b0;
        end else begin
            txPauseRequest <= txControl[`HPQC_TX_PAUSE_GEN_BIT] &
                rxFifoAtThreshold;
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            pauseCount <= 16'h0000;
            pausePrescale <= 10'h000;
        end else if (pauseRxValid & rxControl[`HPQC_RX_PAUSE_HONOR_BIT]) begin
            pauseCount <= pauseRxQuanta;
            pausePrescale <= 10'h000;
        end else if (pauseCount != 16'h0000) begin
            if (pausePrescale == 10'(`HPQC_PAUSE_QUANTUM_CYCLES - 1)) begin
                pausePrescale <= 10'h000;
                pauseCount <= pauseCount - 16'h0001;
            end else begin
                pausePrescale <= pausePrescale + 10'h001;
            end
        end
    end

    // ---------------- transmit path ----------------
    assign txTake = txInValid & txInReady;
    assign outSlot = ~txOutValid | txOutReady;
    assign emitFill = (txState == hpqc_pkg::TX_PAD ||
        txState == hpqc_pkg::TX_FCS) && outSlot;
    assign txCountInc = (txCount == 7'h7f) ? txCount : txCount + 7'h01;
    // with crc appended the pad only has to reach min minus fcs
    assign padTarget = txControl[`HPQC_TX_CRC_BIT] ?
        `HPQC_MIN_FRAME_BYTES - `HPQC_FCS_BYTES : `HPQC_MIN_FRAME_BYTES;
    assign fcsByte = ~txCrc[{fcsIndex, 3'b000} +: 8];

    always_comb begin
        next_txState = txState;
        txDone = 1'b0;
        unique case (txState)
            hpqc_pkg::TX_IDLE: begin
                // a pause or a cleared enable only holds frame starts
                if (txControl[`HPQC_TX_RUN_BIT] && pauseCount == 16'h0000 &&
                    txInValid) begin
                    next_txState = hpqc_pkg::TX_DATA;
                end
            end
            hpqc_pkg::TX_DATA: begin
                if (txTake & txInLast) begin
                    if (txControl[`HPQC_TX_PAD_BIT] && txCountInc < padTarget)
                    begin
                        next_txState = hpqc_pkg::TX_PAD;
                    end else if (txControl[`HPQC_TX_CRC_BIT]) begin
                        next_txState = hpqc_pkg::TX_FCS;
                    end else begin
                        next_txState = hpqc_pkg::TX_IDLE;
                        txDone = 1'b1;
                    end
                end
            end
            hpqc_pkg::TX_PAD: begin
                if (outSlot && txCountInc >= padTarget) begin
                    if (txControl[`HPQC_TX_CRC_BIT]) begin
                        next_txState = hpqc_pkg::TX_FCS;
                    end else begin
                        next_txState = hpqc_pkg::TX_IDLE;
                        txDone = 1'b1;
                    end
                end
            end
            hpqc_pkg::TX_FCS: begin
                if (outSlot && fcsIndex == 2'h3) begin
                    next_txState = hpqc_pkg::TX_IDLE;
                    txDone = 1'b1;
                end
            end
        endcase
        next_txOutValid = (txTake | emitFill) | (txOutValid & ~txOutReady);
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            txState <= hpqc_pkg::TX_IDLE;
            txInReady <= 1'b0;
            txRunning <= 1'b0;
        end else begin
            txState <= next_txState;
            // ready only while the output register will be empty
            txInReady <= (next_txState == hpqc_pkg::TX_DATA) &
                ~next_txOutValid;
            txRunning <= txControl[`HPQC_TX_RUN_BIT] |
                (next_txState != hpqc_pkg::TX_IDLE);
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            txOutValid <= 1'b0;
            txOutData <= 8'h00;
            txOutLast <= 1'b0;
        end else if (txTake) begin
            txOutValid <= 1'b1;
            txOutData <= txInData;
            txOutLast <= txDone;
        end else if (emitFill) begin
            txOutValid <= 1'b1;
            txOutData <= (txState == hpqc_pkg::TX_PAD) ? 8'h00 : fcsByte;
            txOutLast <= txDone;
        end else if (txOutReady) begin
            txOutValid <= 1'b0;
            txOutLast <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset || txState == hpqc_pkg::TX_IDLE) begin
            txCount <= 7'h00;
            fcsIndex <= 2'h0;
        end else begin
            if (txTake || (txState == hpqc_pkg::TX_PAD && outSlot)) begin
                txCount <= txCountInc;
            end
            if (txState == hpqc_pkg::TX_FCS && outSlot) begin
                fcsIndex <= fcsIndex + 2'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            txFrameIdHold <= 6'h00;
            lastTxFrameId <= 6'h00;
        end else begin
            if (txTake && txCount == 7'h00) begin
                txFrameIdHold <= txInFrameId;
            end
            if (txDone) begin
                lastTxFrameId <= (txTake && txCount == 7'h00) ?
                    txInFrameId : txFrameIdHold;
            end
        end
    end

    hpqc_crc32 txCrcUnit (
        .clock(clock),
        .reset(blockReset),
        .start(txState == hpqc_pkg::TX_IDLE),
        .enable(txTake | (txState == hpqc_pkg::TX_PAD && outSlot)),
        .data(txTake ? txInData : 8'h00),
        .state(txCrc)
    );

    // ---------------- receive path ----------------
    // the drain of a kept crc relies on the inter-frame gap
    assign rxFirst = rxInValid & ~rxInFrame;
    assign rxTake = rxInValid & (rxFirst ? rxControl[`HPQC_RX_RUN_BIT] :
        rxActive) & (rxDrain == 3'h0);
    assign rxIndex = rxFirst ? 4'h0 : rxCount;
    assign rxFillCur = rxFirst ? 3'h0 : rxFill;

    always_ff @(posedge clock) begin
        if (blockReset) begin
            rxInFrame <= 1'b0;
            rxActive <= 1'b0;
        end else if (rxInValid) begin
            rxInFrame <= ~rxInLast;
            // the enable is looked at only where a frame begins
            rxActive <= rxInLast ? 1'b0 :
                (rxFirst ? rxControl[`HPQC_RX_RUN_BIT] : rxActive);
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            rxCount <= 4'h0;
            destAddr <= 48'h0000_0000_0000;
            hashIdx <= 6'h00;
        end else begin
            if (rxTake) begin
                rxCount <= (rxIndex == 4'hf) ? rxIndex : rxIndex + 4'h1;
                if (rxIndex <= `HPQC_DEST_LAST_INDEX) begin
                    destAddr <= {rxInData, destAddr[47:8]};
                end
            end
            if (rxCount == `HPQC_HASH_CAPTURE_COUNT) begin
                hashIdx <= rxCrc[31:26];
            end
        end
    end

    hpqc_crc32 rxCrcUnit (
        .clock(clock),
        .reset(blockReset),
        .start(rxFirst),
        .enable(rxTake),
        .data(rxInData),
        .state(rxCrc)
    );

    assign hashSel = (rxCount == `HPQC_HASH_CAPTURE_COUNT) ?
        rxCrc[31:26] : hashIdx;
    assign hashTable = {hashHi, hashLo};
    assign crcBad = rxCrc != `HPQC_CRC_RESIDUE;
    assign isMulticast = destAddr[0];
    assign addrOk = rxControl[`HPQC_RX_PROMISC_BIT] |
        (destAddr == `HPQC_BROADCAST_ADDR &
            rxControl[`HPQC_RX_BCAST_BIT]) |
        (isMulticast & rxControl[`HPQC_RX_MCAST_BIT]) |
        (~isMulticast & destAddr == {stationHi, stationLo} &
            rxControl[`HPQC_RX_UCAST_BIT]) |
        (isMulticast & rxControl[`HPQC_RX_HASH_BIT] &
            hashTable[hashSel]);

    always_ff @(posedge clock) begin
        if (blockReset) begin
            rxEnd <= 1'b0;
            rxEndLong <= 1'b0;
            rxFrameDone <= 1'b0;
            rxFrameAccept <= 1'b0;
            rxFrameCrcError <= 1'b0;
        end else begin
            rxEnd <= rxTake & rxInLast;
            rxEndLong <= rxIndex >= `HPQC_DEST_LAST_INDEX;
            // decision waits one cycle for the last crc update
            rxFrameDone <= rxEnd;
            rxFrameAccept <= rxEnd & rxEndLong & addrOk &
                (~crcBad | rxControl[`HPQC_RX_CRC_ERR_BIT]);
            rxFrameCrcError <= rxEnd & crcBad;
        end
    end

    // four-byte delay line so the crc can be cut off at the end
    always_ff @(posedge clock) begin
        if (blockReset) begin
            rxPipe <= 32'h0000_0000;
            rxFill <= 3'h0;
            rxDrain <= 3'h0;
            rxOutValid <= 1'b0;
            rxOutData <= 8'h00;
            rxOutLast <= 1'b0;
        end else if (rxTake) begin
            rxPipe <= {rxInData, rxPipe[31:8]};
            rxFill <= (rxFillCur == 3'h4) ? rxFillCur : rxFillCur + 3'h1;
            rxOutValid <= rxFillCur == 3'h4;
            rxOutData <= rxPipe[7:0];
            rxOutLast <= rxInLast & rxControl[`HPQC_RX_STRIP_BIT];
            if (rxInLast && !rxControl[`HPQC_RX_STRIP_BIT]) begin
                rxDrain <= (rxFillCur == 3'h4) ? rxFillCur :
                    rxFillCur + 3'h1;
            end
        end else if (rxDrain != 3'h0) begin
            rxOutValid <= 1'b1;
            rxOutData <= rxPipe[{2'(3'h4 - rxDrain), 3'b000} +: 8];
            rxOutLast <= rxDrain == 3'h1;
            rxDrain <= rxDrain - 3'h1;
        end else begin
            rxOutValid <= 1'b0;
            rxOutLast <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (blockReset) begin
            rxRunning <= 1'b0;
        end else begin
            rxRunning <= rxControl[`HPQC_RX_RUN_BIT] | rxActive |
                (rxDrain != 3'h0);
        end
    end
endmodule

// [hw/hpqc_regs.svh]
// register indices, field positions, reset values and timing counts
// Summary of operation
// - pause request while threshold reached and enabled
// - pad short transmit frames to minimum length
// - append CRC to transmit frames when enabled
// - transmit enable starts the transmit path
// - transmit stops only after current frame
// - status shows six-bit identifier of last frame
// - honoured pause holds transmit until timer expires
// - CRC error frames kept only when allowed
// - broadcast accept passes all broadcast frames
// - multicast accept passes multicast and broadcast
// - unicast accept passes station address matches
// - promiscuous mode accepts every frame
// - strip CRC or store it after packet
// - hash enable passes multicast hitting hash table
// - receive enable starts the receive path
// - receive stops only after current frame
// - soft reset returns control fields to defaults
`ifndef HPQC_REGS_SVH
`define HPQC_REGS_SVH

// register indices; byte address is four times the index
`define HPQC_IDX_TX_CONTROL 6'h00
`define HPQC_IDX_TX_STATUS 6'h02
`define HPQC_IDX_RX_CONTROL 6'h04
`define HPQC_IDX_STATION_LO 6'h06
`define HPQC_IDX_STATION_HI 6'h07
`define HPQC_IDX_HASH_LO 6'h08
`define HPQC_IDX_HASH_HI 6'h09
`define HPQC_IDX_RUN_STATUS 6'h0a
`define HPQC_IDX_SOFT_RESET 6'h0b

`define HPQC_TX_PAUSE_GEN_BIT 3
`define HPQC_TX_PAD_BIT 2
`define HPQC_TX_CRC_BIT 1
`define HPQC_TX_RUN_BIT 0
`define HPQC_TX_CONTROL_MASK 16'h600f
`define HPQC_TX_CONTROL_RESET 16'h0000

`define HPQC_RX_PAUSE_HONOR_BIT 10
`define HPQC_RX_CRC_ERR_BIT 9
`define HPQC_RX_BCAST_BIT 7
`define HPQC_RX_MCAST_BIT 6
`define HPQC_RX_UCAST_BIT 5
`define HPQC_RX_PROMISC_BIT 4
`define HPQC_RX_STRIP_BIT 3
`define HPQC_RX_HASH_BIT 2
`define HPQC_RX_RUN_BIT 0
`define HPQC_RX_CONTROL_MASK 16'h06fd
`define HPQC_RX_CONTROL_RESET 16'h0000

`define HPQC_MIN_FRAME_BYTES 7'h40
`define HPQC_FCS_BYTES 7'h04
`define HPQC_DEST_LAST_INDEX 4'h5
`define HPQC_HASH_CAPTURE_COUNT 4'h6
`define HPQC_BROADCAST_ADDR 48'hffff_ffff_ffff

`define HPQC_CRC_INIT 32'hffff_ffff
`define HPQC_CRC_POLY 32'hedb8_8320
`define HPQC_CRC_RESIDUE 32'hdebb_20e3

`define HPQC_CLOCK_PERIOD_NS 8
`define HPQC_PAUSE_QUANTUM_NS 5120
`define HPQC_PAUSE_QUANTUM_CYCLES ((`HPQC_PAUSE_QUANTUM_NS + \
    `HPQC_CLOCK_PERIOD_NS - 1) / `HPQC_CLOCK_PERIOD_NS)

`endif

// [hw/hpqc_pkg.sv]
// types shared by the host port queue control block
package hpqc_pkg;
    typedef enum logic [1:0] {
        TX_IDLE,
        TX_DATA,
        TX_PAD,
        TX_FCS
    } hpqc_tx_state_t;
endpackage

// [hw/hpqc_crc32.sv]
// byte-wide ethernet crc32 accumulator, reflected form
`timescale 1ns/1ns
`include "hpqc_regs.svh"
module hpqc_crc32 (
    input wire logic clock,
    input wire logic reset,
    input wire logic start,
    input wire logic enable,
    input wire logic [7:0] data,
    output logic [31:0] state
);
    logic [31:0] next_state;

    always_comb begin
        next_state = start ? `HPQC_CRC_INIT : state;
        for (int i = 0; i < 8; i++) begin
            if (next_state[0] ^ data[i]) begin
                next_state = (next_state >> 1) ^ `HPQC_CRC_POLY;
            end else begin
                next_state = next_state >> 1;
            end
        end
    end

    // start without enable just reloads the seed for the next frame
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= `HPQC_CRC_INIT;
        end else if (enable) begin
            state <= next_state;
        end else if (start) begin
            state <= `HPQC_CRC_INIT;
        end
    end
endmodule

// [verif/hpqc_control_sva.sv]
// port assertions for the host port queue control block
`timescale 1ns/1ns
module hpqc_control_sva (
    input wire logic clock,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic rxFifoAtThreshold,
    input wire logic txPauseRequest,
    input wire logic txInValid,
    input wire logic txInReady,
    input wire logic txOutValid,
    input wire logic [7:0] txOutData,
    input wire logic txOutLast,
    input wire logic txOutReady,
    input wire logic rxOutValid,
    input wire logic rxOutLast,
    input wire logic rxFrameDone,
    input wire logic rxFrameAccept,
    input wire logic rxFrameCrcError
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_apb_one_wait: assert property (s_access |=> s_answer)
        else $error("apb wait");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("stray pslverr");
    a_pause_cause: assert property (txPauseRequest |-> $past(rxFifoAtThreshold))
        else $error("stray pause");
    a_txout_hold: assert property (txOutValid && !txOutReady |=>
        txOutValid && $stable(txOutData) && $stable(txOutLast))
        else $error("tx byte unstable");
    a_take_gap: assert property (txInValid && txInReady |=> !txInReady)
        else $error("tx ready held");
    a_done_flags: assert property (!rxFrameDone |->
        !rxFrameAccept && !rxFrameCrcError)
        else $error("stray rx flags");
    a_done_pulse: assert property (rxFrameDone |=> !rxFrameDone)
        else $error("rx done long");
    a_rx_last_valid: assert property (rxOutLast |-> rxOutValid)
        else $error("receive last without byte");
    a_tx_last_valid: assert property (txOutLast |-> txOutValid)
        else $error("transmit last without byte");
endmodule
bind hpqc_control hpqc_control_sva hpqc_control_sva_inst (.*);

// [verif/hpqc_mac_sink.sv]
// behavioural mac sink taking transmit bytes, with optional stalls
`timescale 1ns/1ns
module hpqc_mac_sink (
    input wire logic clock,
    input wire logic reset,
    input wire logic slow,
    input wire logic txOutValid,
    input wire logic txOutLast,
    output logic txOutReady,
    output logic [7:0] frameLen,
    output logic [7:0] frameCount
);
    logic [7:0] count;
    // toggling ready makes every pad and crc byte meet a stall in slow mode
    always_ff @(posedge clock) begin
        if (reset) txOutReady <= 1'b0;
        else txOutReady <= slow ? !txOutReady : 1'b1;
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            count <= 8'h00;
            frameLen <= 8'h00;
            frameCount <= 8'h00;
        end else if (txOutValid && txOutReady) begin
            count <= txOutLast ? 8'h00 : count + 8'h01;
            if (txOutLast) begin
                frameLen <= count + 8'h01;
                frameCount <= frameCount + 8'h01;
            end
        end
    end
endmodule

// [verif/tb.sv]
// self-checking bench for the host port queue control block
`timescale 1ns/1ns
module tb;
    logic clock, reset, psel, penable, pwrite, pready, pslverr, err, slow;
    logic [7:0] paddr, txInData, txOutData, rxInData, rxOutData;
    logic [7:0] frameLen, frameCount;
    logic [31:0] pwdata, prdata, rd;
    logic txInValid, txInLast, txInReady, txOutValid, txOutLast, txOutReady;
    logic [5:0] txInFrameId;
    logic rxFifoAtThreshold, txPauseRequest, pauseRxValid, rxInValid, rxInLast;
    logic [15:0] pauseRxQuanta;
    logic rxOutValid, rxOutLast, rxFrameDone, rxFrameAccept, rxFrameCrcError;
    logic txRunning, rxRunning, doneSeen, accSeen, errSeen;
    int n_fail = 0;
    int cmp_count = 0;
    int rxCnt = 0;
    hpqc_control hpqc_control_inst (.*);
    hpqc_mac_sink hpqc_mac_sink_inst (.*);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        if (rxOutValid === 1'b1) rxCnt <= rxCnt + 1;
        if (rxFrameDone === 1'b1) begin
            doneSeen <= 1'b1;
            accSeen <= rxFrameAccept;
            errSeen <= rxFrameCrcError;
        end
    end
    task print_verdict;
        $display("fails %0d compares %0d", n_fail, cmp_count);
        if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask
    task tmo(input string nm);
        $display("Error timeout %s", nm);
        n_fail++;
        print_verdict;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) tmo("apb");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task txf(input logic [5:0] id, input logic [7:0] len, input int minWait);
        int i;
        logic [7:0] fc;
        fc = frameCount;
        @(posedge clock);
        txInValid <= 1'b1;
        txInData <= 8'h5a;
        txInLast <= 1'b1;
        txInFrameId <= id;
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (txInReady !== 1'b1 && i < 2000);
        txInValid <= 1'b0;
        if (txInReady !== 1'b1) tmo("transmit take");
        chk("tx start delay", 32'h1, {31'h0, i >= minWait});
        i = 0;
        do begin
            @(posedge clock);
            i++;
        end while (frameCount === fc && i < 200);
        if (frameCount === fc) tmo("transmit frame");
        chk("tx length", {24'h0, len}, {24'h0, frameLen});
        apb(1'b0, 8'h08, 32'h0);
        chk("tx status", {26'h0, id}, rd);
    endtask
    task rxf(input logic [15:0] ctl, input logic bc, input logic acc,
             input int n);
        int i;
        apb(1'b1, 8'h10, {16'h0, ctl});
        rxCnt <= 0;
        doneSeen <= 1'b0;
        for (i = 0; i < 64; i++) begin
            @(posedge clock);
            rxInValid <= 1'b1;
            rxInData <= (i < 6) ? (bc ? 8'hff : 8'h02) : 8'(i);
            rxInLast <= (i == 63);
        end
        @(posedge clock);
        rxInValid <= 1'b0;
        rxInLast <= 1'b0;
        repeat (12) @(posedge clock);
        chk("rx done", {31'h0, ctl[0]}, {31'h0, doneSeen});
        if (ctl[0]) chk("rx accept", {31'h0, acc}, {31'h0, accSeen});
        if (ctl[0]) chk("rx crc error", 32'h1, {31'h0, errSeen});
        chk("rx bytes", n, rxCnt);
    endtask
    logic [3:0] txCtl [4] = '{4'h7, 4'h3, 4'h5, 4'h1};
    logic [7:0] txLen [4] = '{8'h40, 8'h05, 8'h40, 8'h01};
    initial begin
        {psel, penable, pwrite, paddr, pwdata, txInValid, txInLast} = '0;
        {txInData, txInFrameId, rxFifoAtThreshold, pauseRxValid} = '0;
        {pauseRxQuanta, rxInValid, rxInData, rxInLast, slow} = '0;
        reset = 1'b1;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        apb(1'b0, 8'h00, 32'h0);
        chk("tx control reset", 32'h0, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("rx control reset", 32'h0, rd);
        apb(1'b1, 8'h00, 32'hffff_ffff);
        apb(1'b0, 8'h00, 32'h0);
        chk("tx control mask", 32'h0000_600f, rd);
        apb(1'b1, 8'h10, 32'hffff_ffff);
        apb(1'b0, 8'h10, 32'h0);
        chk("rx control mask", 32'h0000_06fd, rd);
        apb(1'b0, 8'hfc, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, 8'h2c, 32'h1);
        apb(1'b1, 8'h2c, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk("tx control soft reset", 32'h0, rd);
        for (int m = 0; m < 4; m++) begin
            slow <= m[0];
            apb(1'b1, 8'h00, {28'h0, txCtl[m]});
            txf(6'h10 + 6'(m), txLen[m], 0);
        end
        apb(1'b1, 8'h00, 32'h2);
        fork
            txf(6'h21, 8'h05, 40);
            begin
                repeat (60) @(posedge clock);
                apb(1'b1, 8'h00, 32'h3);
            end
        join
        apb(1'b1, 8'h10, 32'h0400);
        pauseRxValid <= 1'b1;
        pauseRxQuanta <= 16'h0001;
        @(posedge clock);
        pauseRxValid <= 1'b0;
        txf(6'h22, 8'h05, 500);
        apb(1'b1, 8'h00, 32'hb);
        rxFifoAtThreshold <= 1'b1;
        repeat (3) @(posedge clock);
        chk("pause request", 32'h1, {31'h0, txPauseRequest});
        rxFifoAtThreshold <= 1'b0;
        repeat (3) @(posedge clock);
        chk("pause release", 32'h0, {31'h0, txPauseRequest});
        rxf(16'h0289, 1'b1, 1'b1, 60);
        rxf(16'h0281, 1'b1, 1'b1, 64);
        rxf(16'h0081, 1'b1, 1'b0, 64);
        rxf(16'h0241, 1'b1, 1'b1, 64);
        rxf(16'h0211, 1'b0, 1'b1, 64);
        rxf(16'h0221, 1'b0, 1'b0, 64);
        rxf(16'h0205, 1'b1, 1'b0, 64);
        apb(1'b1, 8'h20, 32'hffff_ffff);
        apb(1'b1, 8'h24, 32'hffff_ffff);
        rxf(16'h0205, 1'b1, 1'b1, 64);
        rxf(16'h0280, 1'b1, 1'b0, 0);
        print_verdict;
    end
endmodule
